// ===== hdl/qpm_consts.svh
`ifndef QPM_CONSTS_SVH
`define QPM_CONSTS_SVH

`define QPM_PORT_W       8
`define QPM_P1_REDUCED_W 6
`define QPM_LATCH_RST    8'hff
`define QPM_BYTE_ZERO    8'h00

`endif

// ===== hdl/qpm_pin_cell.sv
`timescale 1ns/100ps
`include "qpm_consts.svh"

// One quasi-bidirectional or open-drain port: drive and read-back
module qpm_pin_cell
  import qpm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Latch and bus override
  input  wire qpm_byte_t latchVal,
  input  wire logic      busOwn,
  input  wire qpm_byte_t busVal,
  input  wire logic      busStrongHigh,
  // Pin side
  input  wire qpm_byte_t pinIn,
  output qpm_pins_t      drive,
  output qpm_byte_t      readVal
);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      if (i < WIDTH) begin : g_impl
        logic v;
        assign v = busOwn ? busVal[i] : latchVal[i];
        assign drive.out[i] = v;
        // Strong high only while the bus owns the pin; otherwise only low is driven
        assign drive.oe[i]  = !v || (busOwn && busStrongHigh);
        // A latched zero reads low regardless of the pin
        assign readVal[i]   = latchVal[i] & pinIn[i];
      end else begin : g_none
        // No pin for this bit
        assign drive.out[i] = 1'b0;
        assign drive.oe[i]  = 1'b0;
        assign readVal[i]   = 1'b0;
      end
    end
  endgenerate

endmodule : qpm_pin_cell

// ===== hdl/qpm_pkg.sv
package qpm_pkg;

  typedef logic [7:0] qpm_byte_t;

  typedef enum logic [1:0] {
    QPM_IDLE,
    QPM_ADDR,
    QPM_DATA
  } qpm_state_t;

  // Core-side latch write strobes and data
  typedef struct packed {
    logic [3:0] wrEn;
    qpm_byte_t  wrData;
  } qpm_core_wr_t;

  // External access request from the memory controller
  typedef struct packed {
    logic      start;
    logic      isWrite;
    logic      wide;
    logic [15:0] addr;
    qpm_byte_t wrData;
  } qpm_ext_req_t;

  // Per-pin drive: output value and enable
  typedef struct packed {
    qpm_byte_t out;
    qpm_byte_t oe;
  } qpm_pins_t;

endpackage : qpm_pkg

// ===== hdl/qpm_port_top.sv
`timescale 1ns/100ps
`include "qpm_consts.svh"

module qpm_port_top
  import qpm_pkg::*;
#(
  parameter bit P1_REDUCED = 1'b0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  // Core latch access
  input  wire qpm_core_wr_t coreWr,
  output qpm_byte_t         rdPort0,
  output qpm_byte_t         rdPort1,
  output qpm_byte_t         rdPort2,
  output qpm_byte_t         rdPort3,
  // External memory access
  input  wire qpm_ext_req_t extReq,
  output logic              extBusy,
  output logic              extDone,
  output qpm_byte_t         extRdData,
  // Pins
  input  wire qpm_byte_t    pin0In,
  input  wire qpm_byte_t    pin1In,
  input  wire qpm_byte_t    pin2In,
  input  wire qpm_byte_t    pin3In,
  output qpm_pins_t         pin0,
  output qpm_pins_t         pin1,
  output qpm_pins_t         pin2,
  output qpm_pins_t         pin3,
  // Weak pull-up enables, one per pin of ports 1 to 3
  output qpm_byte_t         pullUp1,
  output qpm_byte_t         pullUp2,
  output qpm_byte_t         pullUp3
);

  typedef struct packed {
    qpm_state_t  st;
    qpm_byte_t   latch0;
    qpm_byte_t   latch1;
    qpm_byte_t   high_port_latch;
    qpm_byte_t   latch3;
    logic        isWrite;
    logic        wide;
    logic [15:0] addr;
    qpm_byte_t   wrData;
    logic        busy;
    logic        done;
    qpm_byte_t   rdData;
    qpm_byte_t   rd0;
    qpm_byte_t   rd1;
    qpm_byte_t   rd2;
    qpm_byte_t   rd3;
    qpm_pins_t   p0;
    qpm_pins_t   p1;
    qpm_pins_t   p2;
    qpm_pins_t   p3;
    qpm_byte_t   pu1;
    qpm_byte_t   pu2;
    qpm_byte_t   pu3;
  } qpm_regs_t;

  localparam int P1_W = P1_REDUCED ? `QPM_P1_REDUCED_W : `QPM_PORT_W;

  qpm_regs_t r;
  qpm_regs_t next_r;

  qpm_pins_t d0, d1, d2, d3;
  qpm_byte_t v0, v1, v2, v3;
  logic      own0, own2;
  qpm_byte_t bus0, bus2;

  // Bus overrides latches only while an access is running
  always_comb begin
    own0 = (r.st != QPM_IDLE);
    own2 = (r.st != QPM_IDLE) && r.wide;
    bus0 = (r.st == QPM_ADDR) ? r.addr[7:0] : r.wrData;
    bus2 = r.addr[15:8];
  end

  // Data phase of a read hands port 0 back to latch0 so memory can drive it
  logic p0Drive;
  assign p0Drive = !(r.st == QPM_DATA && !r.isWrite);

  qpm_pin_cell #(.WIDTH(`QPM_PORT_W)) u_p0 (
    .latchVal      (r.latch0),
    .busOwn        (own0 && p0Drive),
    .busVal        (bus0),
    .busStrongHigh (1'b1),
    .pinIn         (pin0In),
    .drive         (d0),
    .readVal       (v0)
  );
  qpm_pin_cell #(.WIDTH(P1_W)) u_p1 (
    .latchVal      (r.latch1),
    .busOwn        (1'b0),
    .busVal        (`QPM_BYTE_ZERO),
    .busStrongHigh (1'b0),
    .pinIn         (pin1In),
    .drive         (d1),
    .readVal       (v1)
  );
  qpm_pin_cell #(.WIDTH(`QPM_PORT_W)) u_p2 (
    .latchVal      (r.high_port_latch),
    .busOwn        (own2),
    .busVal        (bus2),
    .busStrongHigh (1'b1),
    .pinIn         (pin2In),
    .drive         (d2),
    .readVal       (v2)
  );
  qpm_pin_cell #(.WIDTH(`QPM_PORT_W)) u_p3 (
    .latchVal      (r.latch3),
    .busOwn        (1'b0),
    .busVal        (`QPM_BYTE_ZERO),
    .busStrongHigh (1'b0),
    .pinIn         (pin3In),
    .drive         (d3),
    .readVal       (v3)
  );

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (coreWr.wrEn[0]) begin
      next_r.latch0 = coreWr.wrData;
    end
    if (coreWr.wrEn[1]) begin
      next_r.latch1 = coreWr.wrData;
    end
    if (coreWr.wrEn[2]) begin
      next_r.high_port_latch = coreWr.wrData;
    end
    if (coreWr.wrEn[3]) begin
      next_r.latch3 = coreWr.wrData;
    end
    case (r.st)
      QPM_IDLE: begin
        // Pins lag state by one register, so the read byte stands a cycle after DATA
        if (r.done && !r.isWrite) begin
          next_r.rdData = pin0In;
        end
        if (extReq.start) begin
          next_r.st      = QPM_ADDR;
          next_r.isWrite = extReq.isWrite;
          next_r.wide    = extReq.wide;
          next_r.addr    = extReq.addr;
          next_r.wrData  = extReq.wrData;
        end
      end
      QPM_ADDR: begin
        next_r.st = QPM_DATA;
      end
      QPM_DATA: begin
        next_r.done = 1'b1;
        next_r.st   = QPM_IDLE;
      end
      default: begin
        next_r.st = QPM_IDLE;
      end
    endcase
    next_r.busy = (next_r.st != QPM_IDLE);
    next_r.rd0 = v0;
    next_r.rd1 = v1;
    next_r.rd2 = v2;
    next_r.rd3 = v3;
    next_r.p0  = d0;
    next_r.p1  = d1;
    next_r.p2  = d2;
    next_r.p3  = d3;
    // Port 0 never has a pull-up; the others pull up where a one is latched, port 2 only while the bus does not own it
    next_r.pu1 = r.latch1 & ~d1.oe;
    next_r.pu2 = d2.out & ~d2.oe;
    next_r.pu3 = r.latch3 & ~d3.oe;
    if (P1_REDUCED) begin
      next_r.pu1[7:6] = 2'b00;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r                 <= '0;
      r.st              <= QPM_IDLE;
      r.latch0          <= `QPM_LATCH_RST;
      r.latch1          <= `QPM_LATCH_RST;
      r.high_port_latch <= `QPM_LATCH_RST;
      r.latch3          <= `QPM_LATCH_RST;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign rdPort0   = r.rd0;
  assign rdPort1   = r.rd1;
  assign rdPort2   = r.rd2;
  assign rdPort3   = r.rd3;
  assign extBusy   = r.busy;
  assign extDone   = r.done;
  assign extRdData = r.rdData;
  assign pin0      = r.p0;
  assign pin1      = r.p1;
  assign pin2      = r.p2;
  assign pin3      = r.p3;
  assign pullUp1   = r.pu1;
  assign pullUp2   = r.pu2;
  assign pullUp3   = r.pu3;

endmodule : qpm_port_top

// ===== verification/qpm_pin_model.sv
`timescale 1ns/100ps
// Board pull-downs and external memory on the pins
module qpm_pin_model
  import qpm_pkg::*;
(
  // Clock
  input  wire logic      clock,
  // Device drive
  input  wire qpm_pins_t pin0,
  input  wire qpm_pins_t pin1,
  input  wire qpm_pins_t pin2,
  input  wire qpm_pins_t pin3,
  input  wire qpm_byte_t pullUp1,
  input  wire qpm_byte_t pullUp2,
  input  wire qpm_byte_t pullUp3,
  // Board control
  input  wire logic      memRead,
  input  wire qpm_byte_t extLow,
  // Pin levels
  output qpm_byte_t      pin0In,
  output qpm_byte_t      pin1In,
  output qpm_byte_t      pin2In,
  output qpm_byte_t      pin3In
);
  qpm_byte_t addrLow = 8'h00;
  qpm_byte_t floatVal = 8'h5a;
  // Undriven lines with no pull-up toggle so a stale value never reads as valid
  always_ff @(posedge clock) begin
    if (pin0.oe == 8'hff) begin
      addrLow <= pin0.out;
    end
    floatVal <= ~floatVal;
  end
  function automatic qpm_byte_t level(qpm_pins_t p, qpm_byte_t up);
    return (p.oe & p.out) | (~p.oe & ~extLow & (up | floatVal));
  endfunction : level
  assign pin0In = memRead ? (pin0.oe & pin0.out) | (~pin0.oe & (addrLow ^ 8'hc3))
                          : level(pin0, 8'h00);
  assign pin1In = level(pin1, pullUp1);
  assign pin2In = level(pin2, pullUp2);
  assign pin3In = level(pin3, pullUp3);
endmodule : qpm_pin_model

// ===== verification/qpm_port_monitor.sv
`timescale 1ns/100ps
module qpm_port_monitor
  import qpm_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         rst_n,
  input wire logic         clkEn,
  // Watched ports
  input wire qpm_core_wr_t coreWr,
  input wire qpm_ext_req_t extReq,
  input wire logic         extBusy,
  input wire logic         extDone,
  input wire qpm_pins_t    pin0,
  input wire qpm_pins_t    pin1,
  input wire qpm_pins_t    pin2,
  input wire qpm_byte_t    pullUp1
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic       take;
  logic [1:0] upCnt;
  assign take = extReq.start && !extBusy && clkEn;
  // Outputs read zero for one edge after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      upCnt <= 2'h0;
    end else if (upCnt != 2'h3) begin
      upCnt <= upCnt + 2'h1;
    end
  end
  sequence busy_then_done;
    extBusy [*2] ##1 (extDone && !extBusy);
  endsequence
  done_timing_a: assert property (take |=> busy_then_done)
    else $error("access did not finish on time");
  addr_low_a: assert property (take |-> ##2
    (pin0.oe == 8'hff && pin0.out == $past(extReq.addr[7:0], 2)))
    else $error("low address missing on port 0");
  write_data_a: assert property (take && extReq.isWrite |-> ##3
    (pin0.oe == 8'hff && pin0.out == $past(extReq.wrData, 3)))
    else $error("write byte missing on port 0");
  read_release_a: assert property (take && !extReq.isWrite |-> ##3 pin0.oe == 8'h00)
    else $error("port 0 not released for read");
  high_addr_a: assert property (take && extReq.wide |-> ##2
    (pin2.oe == 8'hff && pin2.out == $past(extReq.addr[15:8], 2)))
    else $error("high address missing on port 2");
  open_drain_a: assert property (upCnt == 2'h3 && !$past(extBusy) |->
    (pin0.oe & pin0.out) == 8'h00)
    else $error("port 0 drove high outside bus use");
  quasi_drive_a: assert property (upCnt == 2'h3 |->
    (pin1.oe & pin1.out) == 8'h00 && pullUp1 == ~pin1.oe)
    else $error("port 1 drive or pull-up wrong");
  latch_write_a: assert property (upCnt == 2'h3 && coreWr.wrEn[1] |-> ##2
    pullUp1 == $past(coreWr.wrData, 2))
    else $error("port 1 latch write not seen");
endmodule : qpm_port_monitor

// ===== verification/qpm_tb.sv
`timescale 1ns/100ps
module testbench
  import qpm_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1, memRead = 1'b0, extBusy, extDone;
  qpm_byte_t rdPort0, rdPort1, rdPort2, rdPort3, extRdData, pullUp1, pullUp2, pullUp3;
  qpm_byte_t pin0In, pin1In, pin2In, pin3In, extLow = 8'h00;
  qpm_pins_t pin0, pin1, pin2, pin3;
  qpm_core_wr_t coreWr = '0;
  qpm_ext_req_t extReq = '0;
  int err_count = 0, checks_done = 0;
  always #5 clock = ~clock;
  qpm_port_top DUT (.clock, .rst_n, .clkEn, .coreWr, .rdPort0, .rdPort1, .rdPort2,
    .rdPort3, .extReq, .extBusy, .extDone, .extRdData, .pin0In, .pin1In, .pin2In,
    .pin3In, .pin0, .pin1, .pin2, .pin3, .pullUp1, .pullUp2, .pullUp3);
  qpm_pin_model board (.clock, .pin0, .pin1, .pin2, .pin3, .pullUp1, .pullUp2,
    .pullUp3, .memRead, .extLow, .pin0In, .pin1In, .pin2In, .pin3In);
  task automatic chk(input bit ok, input string what);
    checks_done++;
    if (!ok) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic wr_latch(input int p, input qpm_byte_t v);
    coreWr.wrEn = 4'h1 << p;
    coreWr.wrData = v;
    tick(1);
    coreWr.wrEn = 4'h0;
    tick(2);
  endtask : wr_latch
  task automatic quasi_port();
    chk(pullUp1 === 8'hff && rdPort1 === 8'hff, "port 1 after reset");
    wr_latch(1, 8'h3c);
    extLow = 8'h06;
    tick(2);
    chk(pin1.oe === 8'hc3 && pullUp1 === 8'h3c, "port 1 drive");
    chk(rdPort1 === 8'h38, "port 1 read");
    extLow = 8'h00;
  endtask : quasi_port
  task automatic open_drain();
    wr_latch(0, 8'h0f);
    tick(1);
    chk(pin0.oe === 8'hf0 && (pin0.out & pin0.oe) === 8'h00, "port 0 drive");
    chk((rdPort0 & 8'hf0) === 8'h00, "port 0 read");
    wr_latch(0, 8'hff);
  endtask : open_drain
  task automatic ext_access(input bit w, input bit wide, input logic [15:0] a,
                            input qpm_byte_t d);
    extReq = '{1'b1, w, wide, a, d};
    memRead = !w;
    tick(1);
    extReq.start = 1'b0;
    tick(1);
    chk(pin0.out === a[7:0] && pin0.oe === 8'hff, "low address");
    if (wide) begin
      chk(pin2.out === a[15:8] && pin2.oe === 8'hff, "high address");
    end else begin
      chk(pin2.out === 8'ha5 && pin2.oe === 8'h5a, "port 2 latch kept");
    end
    // Start while busy must be ignored
    extReq.start = 1'b1;
    tick(1);
    extReq.start = 1'b0;
    chk(extDone === 1'b1 && extBusy === 1'b0, "access end");
    if (w) begin
      chk(pin0.out === d && pin0.oe === 8'hff, "write byte");
    end else begin
      chk(pin0.oe === 8'h00, "port 0 released for read");
    end
    tick(1);
    memRead = 1'b0;
    chk(extBusy === 1'b0 && pin0.oe === 8'h00, "port 0 back to latch");
    if (!w) begin
      chk(extRdData === (a[7:0] ^ 8'hc3), "read byte");
    end
  endtask : ext_access
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    tick(4);
    rst_n = 1'b1;
    tick(3);
    quasi_port();
    open_drain();
    wr_latch(2, 8'ha5);
    ext_access(1'b0, 1'b1, 16'h9a3c, 8'h00);
    ext_access(1'b1, 1'b1, 16'h1234, 8'h6e);
    ext_access(1'b0, 1'b0, 16'h00f1, 8'h00);
    ext_access(1'b1, 1'b0, 16'h0055, 8'hc7);
    complete_run();
  end
endmodule : testbench
bind qpm_port_top qpm_port_monitor mon (.clock, .rst_n, .clkEn, .coreWr, .extReq,
  .extBusy, .extDone, .pin0, .pin1, .pin2, .pullUp1);
